// File: inc/pin_select_regs.svh
/*
 Constants for the shared modem / auxiliary pin selector.
 Assumes inclusion by bare name from the package and the design.
*/
// Summary of operation
// - Each shared pin takes auxiliary, chip select or modem function per select field.
// - Auxiliary mode: bus request output driven low to ask for the bus.
// - Chip-select mode: three pins are active-low selects 6, 7, 8; grant pin output.
// - Modem mode: request-to-send low when modem control bit 2 set.
// - Modem mode: data-terminal-ready low when modem control bit 0 set.
// - Master reset forces request-to-send and data-terminal-ready high.
// - Loop mode holds request-to-send and data-terminal-ready inactive high.
// - Modem status bit 5 reads as inverse of data-set-ready pin.
// - Modem status bit 1 set when data-set-ready changed since last read.
// - Data-set-ready change with modem-status interrupt enabled raises an interrupt.
`ifndef PIN_SELECT_REGS_SVH
`define PIN_SELECT_REGS_SVH
`define MCR_DTR_BIT         0
`define MCR_RTS_BIT         2
`define MSR_DSR_CHANGE_BIT  1
`define MSR_DSR_BIT         5
`define MSR_WIDTH           8
`define MCR_WIDTH           8
`define SEL_AUX             2'h0
`define SEL_CS              2'h1
`define SEL_MODEM           2'h2
`endif

// File: inc/pin_select_pkg.sv
/*
 Types for the shared modem / auxiliary pin selector.
 Assumes the constants header sits on the include path.
*/
`include "pin_select_regs.svh"
package pin_select_pkg;
   typedef enum logic [1:0] {
      FN_AUX   = `SEL_AUX,
      FN_CS    = `SEL_CS,
      FN_MODEM = `SEL_MODEM
   } pin_fn_e;

   typedef struct packed {
      logic aux_bus_request_n;
      logic shared_mem_drive;
      logic extra_select_6_n;
      logic extra_select_7_n;
      logic extra_select_8_n;
   } core_pins_s;

   typedef struct packed {
      logic pin0_o;
      logic pin1_o;
      logic pin1_oe;
      logic pin2_o;
   } shared_pins_s;
endpackage

// File: design/dsr_sync.sv
/*
 Two-flop synchroniser with change detect for the data-set-ready pin.
 Assumes a single core clock with synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module dsr_sync (
   input  wire logic i_core_clk,
   input  wire logic i_srst,
   input  wire logic i_pin,
   input  wire logic i_enable,
   output logic      o_level,
   output logic      o_change
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         meta_ff <= 1'h1;
         sync_ff <= 1'h1;
      end else begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         last_ff <= 1'h1;
      end else begin
         last_ff <= sync_ff;
      end
   end

   assign o_level  = sync_ff;
   assign o_change = i_enable && (sync_ff != last_ff);
endmodule
`default_nettype wire

// File: design/shared_modem_aux_pin_select.sv
/*
 Function selector for the three shared pins: auxiliary bus handshake,
 extra chip selects or modem signals, with modem status and interrupt.
 Assumes the pin ring resolves pin1 from pin1_oe; core logic on i_core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pin_select_regs.svh"
module shared_modem_aux_pin_select
   import pin_select_pkg::*;
(
   input  wire logic                   i_core_clk,
   input  wire logic                   i_srst,
   input  wire logic [1:0]             i_fn_sel,
   input  wire logic [`MCR_WIDTH-1:0]  i_mcr,
   input  wire logic                   i_loop_mode,
   input  wire logic                   i_msi_enable,
   input  wire logic                   i_msr_read,
   input  wire core_pins_s             i_core,
   input  wire logic                   i_pin1,
   output shared_pins_s                o_pins,
   output logic                        o_aux_bus_grant_in_n,
   output logic [`MSR_WIDTH-1:0]       o_msr,
   output logic                        o_modem_irq
);
   ////////////////////////////////////////////////////////////////////////
   // Function select and modem control
   pin_fn_e      fn_ff;
   logic         rts_n_ff;
   logic         dtr_n_ff;
   shared_pins_s pins_ff;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         fn_ff <= FN_AUX;
      end else begin
         case (i_fn_sel)
            `SEL_CS:    fn_ff <= FN_CS;
            `SEL_MODEM: fn_ff <= FN_MODEM;
            default:    fn_ff <= FN_AUX;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         rts_n_ff <= 1'h1;
         dtr_n_ff <= 1'h1;
      end else begin
         rts_n_ff <= i_loop_mode | ~i_mcr[`MCR_RTS_BIT];
         dtr_n_ff <= i_loop_mode | ~i_mcr[`MCR_DTR_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         pins_ff <= '{pin0_o: 1'h1, pin1_o: 1'h1, pin1_oe: 1'h0, pin2_o: 1'h1};
      end else begin
         case (fn_ff)
            FN_AUX: begin
               pins_ff.pin0_o  <= i_core.aux_bus_request_n;
               pins_ff.pin1_o  <= 1'h1;
               pins_ff.pin1_oe <= 1'h0;
               pins_ff.pin2_o  <= i_core.shared_mem_drive;
            end
            FN_CS: begin
               pins_ff.pin0_o  <= i_core.extra_select_6_n;
               pins_ff.pin1_o  <= i_core.extra_select_7_n;
               pins_ff.pin1_oe <= 1'h1;
               pins_ff.pin2_o  <= i_core.extra_select_8_n;
            end
            FN_MODEM: begin
               pins_ff.pin0_o  <= rts_n_ff;
               pins_ff.pin1_o  <= 1'h1;
               pins_ff.pin1_oe <= 1'h0;
               pins_ff.pin2_o  <= dtr_n_ff;
            end
            default: begin
               pins_ff.pin0_o  <= 1'h1;
               pins_ff.pin1_o  <= 1'h1;
               pins_ff.pin1_oe <= 1'h0;
               pins_ff.pin2_o  <= 1'h1;
            end
         endcase
      end
   end
   assign o_pins = pins_ff;

   ////////////////////////////////////////////////////////////////////////
   // Data-set-ready / grant input and status
   logic pin1_level;
   logic pin1_change;
   logic dsr_change_flag_ff;
   logic dsr_bit_ff;
   logic grant_ff;
   logic irq_ff;

   dsr_sync u_dsr_sync (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_pin      (i_pin1),
      .i_enable   (fn_ff == FN_MODEM),
      .o_level    (pin1_level),
      .o_change   (pin1_change)
   );

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         grant_ff <= 1'h1;
      end else begin
         grant_ff <= (fn_ff == FN_AUX) ? pin1_level : 1'h1;
      end
   end
   assign o_aux_bus_grant_in_n = grant_ff;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         dsr_bit_ff <= 1'h0;
      end else begin
         dsr_bit_ff <= (fn_ff == FN_MODEM) & ~pin1_level;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         dsr_change_flag_ff <= 1'h0;
      end else if (pin1_change) begin
         dsr_change_flag_ff <= 1'h1;
      end else if (i_msr_read) begin
         dsr_change_flag_ff <= 1'h0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         irq_ff <= 1'h0;
      end else begin
         irq_ff <= i_msi_enable & (dsr_change_flag_ff | pin1_change);
      end
   end
   assign o_modem_irq = irq_ff;

   always_comb begin
      o_msr = '0;
      o_msr[`MSR_DSR_BIT]        = dsr_bit_ff;
      o_msr[`MSR_DSR_CHANGE_BIT] = dsr_change_flag_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_dsr_edge;
      pin1_change;
   endsequence

   sequence s_sync_clean;
      !$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3);
   endsequence

   sequence s_flag_pending;
      dsr_change_flag_ff && !i_msr_read;
   endsequence

   chk_reset_inactive: assert property (@(posedge i_core_clk)
      $past(i_srst) |-> rts_n_ff && dtr_n_ff)
      else $error("modem outputs not inactive after reset");
   chk_loop_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
      $past(i_loop_mode) && !$past(i_srst) |-> rts_n_ff && dtr_n_ff)
      else $error("loop mode did not hold modem outputs");
   chk_rts_drive: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_MODEM && $past(fn_ff) == FN_MODEM |=> o_pins.pin0_o == $past(rts_n_ff))
      else $error("rts pin mismatch");
   chk_dtr_drive: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_MODEM && $past(fn_ff) == FN_MODEM |=> o_pins.pin2_o == $past(dtr_n_ff))
      else $error("dtr pin mismatch");
   chk_cs_output: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_CS |=> o_pins.pin1_oe)
      else $error("select pin not driven");
   chk_aux_req: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_AUX |=> o_pins.pin0_o == $past(i_core.aux_bus_request_n))
      else $error("bus request not passed");
   chk_flag_set: assert property (@(posedge i_core_clk) disable iff (i_srst)
      s_dsr_edge |=> dsr_change_flag_ff)
      else $error("change flag not set");
   chk_flag_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_msr_read && !pin1_change |=> !dsr_change_flag_ff)
      else $error("change flag not cleared by read");
   chk_irq_raise: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (s_dsr_edge and i_msi_enable) |=> o_modem_irq)
      else $error("no interrupt on change");
   chk_reset_pins: assert property (@(posedge i_core_clk)
      $past(i_srst) |-> o_pins.pin0_o && o_pins.pin2_o && !o_pins.pin1_oe)
      else $error("shared pins not idle after reset");
   chk_cs_selects: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_CS |=> o_pins.pin0_o == $past(i_core.extra_select_6_n)
         && o_pins.pin1_o == $past(i_core.extra_select_7_n)
         && o_pins.pin2_o == $past(i_core.extra_select_8_n))
      else $error("select pins not passed");
   chk_aux_drive: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_AUX |=> o_pins.pin2_o == $past(i_core.shared_mem_drive) && !o_pins.pin1_oe)
      else $error("auxiliary pins wrong");
   chk_modem_input: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_MODEM |=> !o_pins.pin1_oe)
      else $error("status pin driven in modem mode");
   chk_grant_follow: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_AUX |=> o_aux_bus_grant_in_n == $past(pin1_level))
      else $error("grant does not follow pin");
   chk_grant_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff != FN_AUX |=> o_aux_bus_grant_in_n)
      else $error("grant active outside auxiliary mode");
   chk_dsr_status: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff == FN_MODEM |=> o_msr[`MSR_DSR_BIT] == !$past(pin1_level))
      else $error("ready status not inverse of pin");
   chk_dsr_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fn_ff != FN_MODEM |=> !o_msr[`MSR_DSR_BIT])
      else $error("ready status set outside modem mode");
   chk_sync_delay: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (s_dsr_edge and s_sync_clean) |-> $past(i_pin1, 2) != $past(i_pin1, 3))
      else $error("change not two flops behind pin");
   chk_flag_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
      s_flag_pending |=> dsr_change_flag_ff)
      else $error("change flag lost without read");
   chk_irq_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
      dsr_change_flag_ff && i_msi_enable |=> o_modem_irq)
      else $error("interrupt dropped while flag set");
   chk_irq_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !i_msi_enable |=> !o_modem_irq)
      else $error("interrupt while disabled");
endmodule
`default_nettype wire

// File: dv/modem_aux_partner.sv
/*
 Far-side model: auxiliary processor grant, or modem data-set-ready.
 Assumes the bench resolves shared pin 1 from the design's enable.
*/
`timescale 1ns/1ns
`default_nettype none
module modem_aux_partner
   import pin_select_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic [1:0]   i_fn_sel,
   input  wire shared_pins_s i_pins,
   input  wire logic         i_dsr_n,
   output logic              o_pin1
);
   initial o_pin1 = 1'b1;
   // While the design drives the pin: toggling pattern, ignored by the bench
   always @(posedge i_core_clk) begin
      if (i_pins.pin1_oe) begin
         o_pin1 <= ~o_pin1;
      end else if (i_fn_sel == FN_MODEM) begin
         o_pin1 <= i_dsr_n;
      end else begin
         o_pin1 <= i_pins.pin0_o;
      end
   end
endmodule
`default_nettype wire

// File: dv/test_shared_modem_aux_pin_select.sv
/*
 Bench for the shared pin selector: all three functions, modem status.
 Assumes the partner model drives pin 1 whenever the design releases it.
*/
`timescale 1ns/1ns
`default_nettype none
module test_shared_modem_aux_pin_select
   import pin_select_pkg::*;
;
   logic         clk, srst, loop_m, msi, rd, dsr_n, part_lvl, pin1_w, grant_n, irq;
   logic [1:0]   fn;
   logic [7:0]   mcr, msr;
   core_pins_s   core;
   shared_pins_s pins;
   int           failures, num_checks, i;
   assign pin1_w = pins.pin1_oe ? pins.pin1_o : part_lvl;
   always #20 clk = ~clk;
   shared_modem_aux_pin_select DUT (.i_core_clk(clk), .i_srst(srst), .i_fn_sel(fn),
      .i_mcr(mcr), .i_loop_mode(loop_m), .i_msi_enable(msi), .i_msr_read(rd),
      .i_core(core), .i_pin1(pin1_w), .o_pins(pins), .o_aux_bus_grant_in_n(grant_n),
      .o_msr(msr), .o_modem_irq(irq));
   modem_aux_partner far_end (.i_core_clk(clk), .i_fn_sel(fn), .i_pins(pins),
      .i_dsr_n(dsr_n), .o_pin1(part_lvl));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic bad(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_pins(input shared_pins_s e);
      shared_pins_s g;
      g = pins;
      if (e.pin1_oe !== 1'b1) g.pin1_o = e.pin1_o;
      bad({4'h0, g}, {4'h0, e});
   endtask
   task automatic chk_msr(input logic [7:0] e);
      bad(msr, e);
   endtask
   task automatic chk_bit(input logic g, input logic e);
      bad({7'h00, g}, {7'h00, e});
   endtask
   task automatic read_msr();
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      clk = 1'b0; srst = 1'b1; fn = 2'h0; mcr = 8'h00; loop_m = 1'b0;
      msi = 1'b0; rd = 1'b0; core = 5'h1F; dsr_n = 1'b1; failures = 0; num_checks = 0;
      wt(7);
      chk_pins(4'hD);
      chk_msr(8'h00);
      @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         fn <= 2'h1;
         core <= {2'h3, (i == 0) ? 3'h2 : 3'h5};
         wt(4);
         chk_pins({core[2], core[1], 1'b1, core[0]});
         chk_bit(grant_n, 1'b1);
      end
      @(posedge clk);
      fn <= 2'h0;
      core <= 5'h0F;
      wt(6);
      chk_pins(4'h5);
      chk_bit(grant_n, 1'b0);
      @(posedge clk);
      fn <= 2'h3;
      core <= 5'h17;
      wt(6);
      chk_pins(4'hC);
      chk_bit(grant_n, 1'b1);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         fn <= 2'h2;
         mcr <= {5'h00, i[1], 1'b0, i[0]};
         loop_m <= i[2];
         wt(4);
         chk_pins({~(i[1] & ~i[2]), 2'h2, ~(i[0] & ~i[2])});
      end
      chk_msr(8'h00);
      @(posedge clk);
      loop_m <= 1'b0;
      msi <= 1'b1;
      dsr_n <= 1'b0;
      wt(4);
      chk_msr(8'h22);
      chk_bit(irq, 1'b1);
      read_msr();
      wt(3);
      chk_msr(8'h20);
      chk_bit(irq, 1'b0);
      @(posedge clk);
      msi <= 1'b0;
      dsr_n <= 1'b1;
      wt(4);
      chk_msr(8'h02);
      chk_bit(irq, 1'b0);
      read_msr();
      wt(2);
      chk_msr(8'h00);
      @(posedge clk);
      mcr <= 8'h05;
      wt(4);
      chk_pins(4'h0);
      @(posedge clk);
      srst <= 1'b1;
      wt(2);
      chk_pins(4'hD);
      @(posedge clk);
      srst <= 1'b0;
      end_of_test();
   end
endmodule
`default_nettype wire
